/* File: core/ess_defs.svh */
// constants for the eeprom signature scan stepper
// assumes byte addresses of at most 16 bits
`ifndef ESS_DEFS_SVH
`define ESS_DEFS_SVH

// ----------------------------------------
// signature and widths
// ----------------------------------------
`define ESS_SIGNATURE 32'hEEC0_DE1F
`define ESS_ADDR_W 16
`define ESS_SCAN_START 16'h0000

// ----------------------------------------
// log2 of automatic step, short format
// ----------------------------------------
`define ESS_S00_STEP_LOG2 5'h05
`define ESS_S10_STEP_LOG2 5'h07
`define ESS_S11_STEP_LOG2 5'h08

// ----------------------------------------
// log2 of automatic step, long format
// ----------------------------------------
`define ESS_L00_STEP_LOG2 5'h0A
`define ESS_L10_STEP_LOG2 5'h0B
`define ESS_L11_STEP_LOG2 5'h0C

// ----------------------------------------
// log2 of scan range
// ----------------------------------------
`define ESS_S00_RANGE_LOG2 5'h08
`define ESS_S10_RANGE_LOG2 5'h0A
`define ESS_S11_RANGE_LOG2 5'h0B
`define ESS_L00_RANGE_LOG2 5'h0C
`define ESS_L10_RANGE_LOG2 5'h0E
`define ESS_L11_RANGE_LOG2 5'h0F

// ----------------------------------------
// step modifier codes and strap settle
// ----------------------------------------
`define ESS_MOD_AUTO_LO 4'h0
`define ESS_MOD_AUTO_HI 4'hF
`define ESS_STRAP_SETTLE 2'h3

`endif

/* File: core/ess_pkg.sv */
// types for the eeprom signature scan stepper
// assumes ess_defs.svh sits beside it
package ess_pkg;

  // ----------------------------------------
  // strap bundle
  // ----------------------------------------
  typedef struct packed {
    logic eeprom_address_format_select;
    logic [1:0] scan_size;
    logic [3:0] step_mod;
  } ess_strap_t;

  // ----------------------------------------
  // read request towards the i2c engine
  // ----------------------------------------
  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } ess_rd_req_t;

  typedef enum logic [2:0] {
    ESS_ST_SETTLE,
    ESS_ST_WAIT,
    ESS_ST_REQ,
    ESS_ST_FOUND,
    ESS_ST_ABSENT
  } ess_state_t;

endpackage

/* File: core/ess_scan_stepper.sv */
// eeprom signature scan stepper: walks scan addresses and checks signature
// assumes an i2c engine on CLK_I that reads four bytes per request
//
// Overview of operation
// - scan runs after power-up and after every reset, once START_I is seen high after the settle window.
// - first scan address is zero, then advance by the step.
// - short format, size 00: 256 bytes, step 32.
// - short format, size 10: 1024 bytes, step 128.
// - short format, size 11: 2048 bytes, step 256.
// - long format, size 00: 4096 bytes, step 1024.
// - long format, size 10: 16384 bytes, step 2048.
// - long format, size 11: 32768 bytes, step 4096.
// - modifier 0000 or 1111 keeps the automatic step.
// - modifier top bit clear multiplies step by two to the low bits.
// - finer steps by dividing down to one 64th are offered.
// - found record address always lies inside the scan range.
// - format strap zero selects short addressing, one selects 16-bit.
// - four bytes read are compared against fixed signature.
// - no signature in range ends search with no further reads.
`timescale 1ns/1ps
`include "ess_defs.svh"

module ess_scan_stepper
  import ess_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // strap pins
  input wire logic ADDR_FORMAT_SEL_I,
  input wire logic [1:0] SCAN_SIZE_I,
  input wire logic [3:0] STEP_MOD_I,
  // start from eeprom detection
  input wire logic START_I,
  // read channel to i2c engine
  output logic RD_REQ_O,
  output logic [15:0] RD_ADDR_O,
  input wire logic RD_DONE_I,
  input wire logic RD_ERR_I,
  input wire logic [31:0] RD_DATA_I,
  // status
  output logic BUSY_O,
  output logic FOUND_O,
  output logic ABSENT_O,
  output logic [15:0] RECORD_ADDR_O
);

  // ----------------------------------------
  // step and range decode
  // ----------------------------------------
  function automatic logic [4:0] ess_auto_log2(input ess_strap_t s);
    logic [4:0] v;
    v = `ESS_S00_STEP_LOG2;
    if (!s.eeprom_address_format_select) begin
      if (s.scan_size == 2'h2) v = `ESS_S10_STEP_LOG2;
      if (s.scan_size == 2'h3) v = `ESS_S11_STEP_LOG2;
    end else begin
      v = `ESS_L00_STEP_LOG2;
      if (s.scan_size == 2'h2) v = `ESS_L10_STEP_LOG2;
      if (s.scan_size == 2'h3) v = `ESS_L11_STEP_LOG2;
    end
    return v;
  endfunction

  function automatic logic [4:0] ess_range_log2(input ess_strap_t s);
    logic [4:0] v;
    v = `ESS_S00_RANGE_LOG2;
    if (!s.eeprom_address_format_select) begin
      if (s.scan_size == 2'b10) v = `ESS_S10_RANGE_LOG2;
      if (s.scan_size == 2'b11) v = `ESS_S11_RANGE_LOG2;
    end else begin
      v = `ESS_L00_RANGE_LOG2;
      if (s.scan_size == 2'b10) v = `ESS_L10_RANGE_LOG2;
      if (s.scan_size == 2'b11) v = `ESS_L11_RANGE_LOG2;
    end
    return v;
  endfunction

  function automatic logic [4:0] ess_step_log2(input ess_strap_t s);
    logic [4:0] b;
    logic [4:0] k;
    b = ess_auto_log2(s);
    k = {2'b00, s.step_mod[2:0]};
    if (s.step_mod == `ESS_MOD_AUTO_LO || s.step_mod == `ESS_MOD_AUTO_HI) begin
      return b;
    end
    if (!s.step_mod[3]) begin
      return 5'(b + k);
    end
    return (b >= k) ? 5'(b - k) : 5'h00;
  endfunction

  // ----------------------------------------
  // strap synchronisers and capture
  // ----------------------------------------
  ess_strap_t strap_s1_r;
  ess_strap_t strap_s2_r;
  ess_strap_t strap_r;
  ess_strap_t strap_nxt;
  logic [1:0] settle_r;
  logic start_s1_r;
  logic start_s2_r;

  assign strap_nxt = '{eeprom_address_format_select: ADDR_FORMAT_SEL_I, scan_size: SCAN_SIZE_I,
                       step_mod: STEP_MOD_I};

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
    end else begin
      strap_s1_r <= strap_nxt;
      strap_s2_r <= strap_s1_r;
      start_s1_r <= START_I;
      start_s2_r <= start_s1_r;
    end
  end

  // ----------------------------------------
  // derived step and limit
  // ----------------------------------------
  logic [4:0] step_log2;
  logic [4:0] range_log2;
  logic [16:0] step_val;
  logic [16:0] limit_val;
  logic [16:0] addr_next;
  logic step_too_big;
  logic sig_match;
  logic last_addr;

  assign step_log2 = ess_step_log2(strap_r);
  assign range_log2 = ess_range_log2(strap_r);
  assign step_too_big = (step_log2 >= range_log2);
  assign step_val = step_too_big ? limit_val : (17'h0_0001 << step_log2);
  assign limit_val = 17'h0_0001 << range_log2;
  assign addr_next = {1'b0, RD_ADDR_O} + step_val;
  assign last_addr = (addr_next >= limit_val);
  assign sig_match = (RD_DATA_I == `ESS_SIGNATURE) && !RD_ERR_I;

  // ----------------------------------------
  // scan state machine
  // ----------------------------------------
  ess_state_t state_r;
  ess_state_t state_nxt;
  ess_rd_req_t rd_r;
  ess_rd_req_t rd_nxt;
  logic [15:0] rec_r;
  logic [15:0] rec_nxt;
  logic [1:0] settle_nxt;

  always_comb begin
    state_nxt = state_r;
    rd_nxt = rd_r;
    rec_nxt = rec_r;
    settle_nxt = settle_r;
    case (state_r)
      ESS_ST_SETTLE: begin
        settle_nxt = 2'(settle_r + 2'h1);
        if (settle_r == `ESS_STRAP_SETTLE) begin
          state_nxt = ESS_ST_WAIT;
        end
      end
      ESS_ST_WAIT: begin
        if (start_s2_r) begin
          state_nxt = ESS_ST_REQ;
          rd_nxt.req = 1'b1;
          rd_nxt.addr = `ESS_SCAN_START;
        end
      end
      ESS_ST_REQ: begin
        if (RD_DONE_I) begin
          if (sig_match) begin
            state_nxt = ESS_ST_FOUND;
            rd_nxt.req = 1'b0;
            rec_nxt = rd_r.addr;
          end else if (last_addr) begin
            state_nxt = ESS_ST_ABSENT;
            rd_nxt.req = 1'b0;
          end else begin
            rd_nxt.addr = addr_next[15:0];
          end
        end
      end
      ESS_ST_FOUND: begin
        state_nxt = ESS_ST_FOUND;
      end
      ESS_ST_ABSENT: begin
        state_nxt = ESS_ST_ABSENT;
      end
      default: begin
        state_nxt = ESS_ST_SETTLE;
        rd_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_r <= ESS_ST_SETTLE;
      rd_r <= '0;
      rec_r <= '0;
      settle_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      rd_r <= rd_nxt;
      rec_r <= rec_nxt;
      settle_r <= settle_nxt;
    end
  end

  // straps frozen once settled, format select included
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      strap_r <= '0;
    end else if (state_r == ESS_ST_SETTLE) begin
      strap_r <= strap_s2_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RD_REQ_O = rd_r.req;
  assign RD_ADDR_O = rd_r.addr;
  assign BUSY_O = (state_r == ESS_ST_REQ);
  assign FOUND_O = (state_r == ESS_ST_FOUND);
  assign ABSENT_O = (state_r == ESS_ST_ABSENT);
  assign RECORD_ADDR_O = rec_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  AST_FIRST_ADDR_ZERO: assert property ($rose(RD_REQ_O) |-> RD_ADDR_O == 16'h0000)
    else $error("scan did not start at address zero");
  AST_STEP_ADVANCE: assert property (RD_REQ_O && RD_DONE_I && !sig_match && !last_addr
    |=> RD_REQ_O && RD_ADDR_O == 16'($past(RD_ADDR_O) + $past(step_val)))
    else $error("scan address did not advance by one step");
  AST_ADDR_ALIGNED: assert property (RD_REQ_O && !step_too_big
    |-> (RD_ADDR_O & 16'(step_val - 17'h0_0001)) == 16'h0000)
    else $error("scan address not a multiple of the step");
  AST_ADDR_IN_RANGE: assert property (RD_REQ_O |-> {1'b0, RD_ADDR_O} < limit_val)
    else $error("scan address beyond scan range");
  AST_BUSY_REQ: assert property (BUSY_O == RD_REQ_O)
    else $error("busy and read request disagree");
  AST_MATCH_STOPS: assert property (RD_REQ_O && RD_DONE_I && sig_match
    |=> FOUND_O && !RD_REQ_O && RECORD_ADDR_O == $past(RD_ADDR_O))
    else $error("signature match did not end the scan");
  AST_RECORD_HOLD: assert property (FOUND_O |=> FOUND_O && $stable(RECORD_ADDR_O))
    else $error("record address moved after the match");
  AST_ABSENT_QUIET: assert property (ABSENT_O |=> (ABSENT_O && !RD_REQ_O) [*4])
    else $error("read issued after an unsuccessful scan");
  AST_START_AFTER_WAIT: assert property (state_r == ESS_ST_WAIT && start_s2_r |=> RD_REQ_O)
    else $error("scan not started on start request");
  AST_FORMAT_HOLD: assert property (state_r != ESS_ST_SETTLE |=> $stable(strap_r))
    else $error("straps changed after the settle window");

  // step modifier against the automatic step
  AST_AUTO_STEP: assert property ((strap_r.step_mod == 4'h0 || strap_r.step_mod == 4'hF)
    |-> step_log2 == ess_auto_log2(strap_r))
    else $error("automatic step altered");
  AST_MUL_STEP: assert property (!strap_r.step_mod[3] && strap_r.step_mod[2:0] != 3'h0
    |-> step_log2 == 5'(ess_auto_log2(strap_r) + {2'b00, strap_r.step_mod[2:0]}))
    else $error("multiplied step wrong");
  AST_DIV_STEP: assert property (strap_r.step_mod[3] && strap_r.step_mod != 4'hF
    && ess_auto_log2(strap_r) >= {2'b00, strap_r.step_mod[2:0]}
    |-> step_log2 == 5'(ess_auto_log2(strap_r) - {2'b00, strap_r.step_mod[2:0]}))
    else $error("divided step wrong");
  AST_DIV_FLOOR: assert property (strap_r.step_mod[3] && strap_r.step_mod != 4'hF
    && ess_auto_log2(strap_r) < {2'b00, strap_r.step_mod[2:0]} |-> step_log2 == 5'h00)
    else $error("divided step did not floor at one byte");

  // scan size decode against fixed sizes and steps
  AST_SHORT_S00: assert property (!strap_r.eeprom_address_format_select && strap_r.scan_size == 2'h0
    |-> limit_val == 17'h0_0100 && (17'h0_0001 << ess_auto_log2(strap_r)) == 17'h0_0020)
    else $error("short format size 00 decode wrong");
  AST_SHORT_S10: assert property (!strap_r.eeprom_address_format_select && strap_r.scan_size == 2'h2
    |-> limit_val == 17'h0_0400 && (17'h0_0001 << ess_auto_log2(strap_r)) == 17'h0_0080)
    else $error("short format size 10 decode wrong");
  AST_SHORT_S11: assert property (!strap_r.eeprom_address_format_select && strap_r.scan_size == 2'h3
    |-> range_log2 == 5'h0B && ess_auto_log2(strap_r) == 5'h08)
    else $error("short format size 11 decode wrong");
  AST_LONG_S00: assert property (strap_r.eeprom_address_format_select && strap_r.scan_size == 2'h0
    |-> limit_val == 17'h0_1000 && (17'h0_0001 << ess_auto_log2(strap_r)) == 17'h0_0400)
    else $error("long format size 00 decode wrong");
  AST_LONG_S10: assert property (strap_r.eeprom_address_format_select && strap_r.scan_size == 2'h2
    |-> range_log2 == 5'h0E && ess_auto_log2(strap_r) == 5'h0B)
    else $error("long format size 10 decode wrong");
  AST_LONG_S11: assert property (strap_r.eeprom_address_format_select && strap_r.scan_size == 2'h3
    |-> limit_val == 17'h0_8000 && (17'h0_0001 << ess_auto_log2(strap_r)) == 17'h0_1000)
    else $error("long format size 11 decode wrong");

  COV_FOUND: cover property (RD_REQ_O && RD_DONE_I && sig_match);
  COV_ABSENT: cover property ($rose(ABSENT_O));
  COV_MULTI_STEP: cover property (RD_REQ_O && RD_DONE_I && !sig_match
    ##2 RD_REQ_O && RD_DONE_I && sig_match ##1 FOUND_O);
  COV_LONG_FORMAT: cover property (RD_REQ_O && strap_r.eeprom_address_format_select);
  COV_BYTE_STEP: cover property (RD_REQ_O && RD_DONE_I && step_log2 == 5'h00);

endmodule

/* File: test/ess_eeprom_model.sv */
// read engine and eeprom model behind the scan stepper read channel
// assumes requests come from ess_scan_stepper on the same clock
`timescale 1ns/1ps

module ess_eeprom_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // read channel
  input wire logic req_i,
  input wire logic [15:0] addr_i,
  output logic done_o,
  output logic err_o,
  output logic [31:0] data_o,
  // scenario control
  input wire logic [7:0] delay_i,
  input wire logic [15:0] sig_addr_i,
  input wire logic [15:0] err_addr_i
);
  logic [7:0] cnt_r;
  logic [15:0] last_r;
  logic served_r;
  logic new_rd;

  // a changed address is a new read
  assign new_rd = req_i && !done_o && !(served_r && addr_i == last_r);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 8'h00;
      last_r <= 16'h0000;
      served_r <= 1'b0;
      done_o <= 1'b0;
      err_o <= 1'b0;
      data_o <= 32'h5A5A_A5A5;
    end else begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      // data not valid outside done: keep it moving
      data_o <= ~data_o;
      if (new_rd) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r >= delay_i) begin
          cnt_r <= 8'h00;
          served_r <= 1'b1;
          last_r <= addr_i;
          done_o <= 1'b1;
          err_o <= (addr_i == err_addr_i);
          data_o <= (addr_i == sig_addr_i) ? 32'hEEC0_DE1F : {addr_i, ~addr_i};
        end
      end
    end
  end
endmodule

/* File: test/testbench.sv */
// self-checking bench for the scan stepper
// assumes ess_pkg, ess_scan_stepper and ess_eeprom_model are compiled first
`timescale 1ns/1ps

module testbench;
  import ess_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  ess_strap_t strap = '0;
  logic rd_req, rd_done, rd_err, busy, found, absent;
  logic [15:0] rd_addr, rec_addr;
  logic [31:0] rd_data;
  logic [7:0] dly = 8'h00;
  logic [15:0] sig_addr = 16'hFFFF;
  logic [15:0] err_addr = 16'hFFFF;
  int error_cnt = 0;
  int samples_checked = 0;
  int exp_addr = 0;
  int step = 1;
  int reads = 0;
  int auto_lg[8] = '{5, 5, 7, 8, 10, 10, 11, 12};
  int lim_lg[8] = '{8, 8, 10, 11, 12, 12, 14, 15};

  always #20 clk = ~clk;

  ess_scan_stepper u_ess_scan_stepper (
    .CLK_I(clk), .RSTN_I(rstn), .ADDR_FORMAT_SEL_I(strap.eeprom_address_format_select),
    .SCAN_SIZE_I(strap.scan_size), .STEP_MOD_I(strap.step_mod), .START_I(start),
    .RD_REQ_O(rd_req), .RD_ADDR_O(rd_addr), .RD_DONE_I(rd_done), .RD_ERR_I(rd_err),
    .RD_DATA_I(rd_data), .BUSY_O(busy), .FOUND_O(found), .ABSENT_O(absent),
    .RECORD_ADDR_O(rec_addr));

  ess_eeprom_model u_ess_eeprom_model (
    .clk_i(clk), .rstn_i(rstn), .req_i(rd_req), .addr_i(rd_addr), .done_o(rd_done),
    .err_o(rd_err), .data_o(rd_data), .delay_i(dly), .sig_addr_i(sig_addr),
    .err_addr_i(err_addr));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // every completed read must sit on the next step multiple
  always @(posedge clk) begin
    if (rstn && rd_done && rd_req) begin
      check({16'h0000, rd_addr}, 32'(exp_addr));
      exp_addr = exp_addr + step;
      reads++;
    end
  end

  // ----------------------------------------
  // one scan from reset, optionally cut short by a reset
  // ----------------------------------------
  task automatic run_scan(input string name, input logic fmt, input logic [1:0] size,
      input logic [3:0] smod, input logic [15:0] sig, input logic [7:0] d, input int abort);
    int lg;
    int lim;
    int n;
    logic hit;
    lg = auto_lg[{fmt, size}];
    lim = 1 << lim_lg[{fmt, size}];
    if (smod != 4'h0 && smod != 4'hF) begin
      lg = smod[3] ? lg - int'(smod[2:0]) : lg + int'(smod[2:0]);
    end
    step = 1 << ((lg < 0) ? 0 : lg);
    n = (lim > step) ? lim / step : 1;
    hit = (int'(sig) % step == 0) && (int'(sig) / step < n) && (sig != err_addr);
    if (hit) begin
      n = int'(sig) / step + 1;
    end
    strap = '{fmt, size, smod};
    sig_addr = sig;
    dly = d;
    start = 1'b1;
    for (int r = (abort > 0) ? 0 : 1; r < 2; r++) begin
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      exp_addr = 0;
      reads = 0;
      rstn = 1'b1;
      if (r == 0) begin
        repeat (abort) @(negedge clk);
      end
    end
    for (int i = 0; i < 2000 && found !== 1'b1 && absent !== 1'b1; i++) begin
      @(negedge clk);
    end
    check(32'(reads), 32'(n));
    check(32'(found), 32'(hit));
    check(32'(absent), 32'(!hit));
    check({16'h0000, rec_addr}, hit ? {16'h0000, sig} : 32'h0000_0000);
    repeat (8) @(negedge clk);
    check(32'(reads), 32'(n));
    check({31'h0, rd_req, busy}, 32'h0000_0000);
    start = 1'b0;
    err_addr = 16'hFFFF;
    $display("test %s done", name);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_short_small; run_scan("short_small", 1'b0, 2'b00, 4'h0, 16'h0040, 8'h00, 0); endtask
  task automatic t_short_mid; run_scan("short_mid", 1'b0, 2'b10, 4'hF, 16'h0380, 8'h05, 0); endtask
  task automatic t_short_big; run_scan("short_big", 1'b0, 2'b11, 4'h0, 16'hFFFF, 8'h01, 0); endtask
  task automatic t_long_small; run_scan("long_small", 1'b1, 2'b00, 4'h1, 16'hFFFF, 8'h00, 0); endtask
  task automatic t_long_mid; run_scan("long_mid", 1'b1, 2'b10, 4'h2, 16'h2000, 8'h03, 0); endtask
  task automatic t_long_big; run_scan("long_big", 1'b1, 2'b11, 4'hA, 16'hFFFF, 8'h00, 0); endtask
  task automatic t_fine; run_scan("fine", 1'b1, 2'b11, 4'hE, 16'h2000, 8'h00, 0); endtask
  task automatic t_coarse; run_scan("coarse", 1'b0, 2'b00, 4'h7, 16'hFFFF, 8'h02, 0); endtask
  task automatic t_rerun; run_scan("rerun", 1'b0, 2'b10, 4'h0, 16'h0100, 8'h02, 14); endtask
  task automatic t_size_alias; run_scan("size_alias", 1'b1, 2'b01, 4'h9, 16'h0600, 8'h01, 0); endtask
  task automatic t_finest; run_scan("finest", 1'b0, 2'b00, 4'hE, 16'h0005, 8'h01, 0); endtask

  task automatic t_err_miss;
    err_addr = 16'h0020;
    run_scan("err_miss", 1'b0, 2'b00, 4'h8, 16'h0020, 8'h01, 0);
  endtask

  initial begin
    repeat (16) @(negedge clk);
    t_short_small();
    t_short_mid();
    t_short_big();
    t_long_small();
    t_long_mid();
    t_long_big();
    t_fine();
    t_coarse();
    t_rerun();
    t_err_miss();
    t_size_alias();
    t_finest();
    stop_test();
  end

  // twelve scans need well under a thousand cycles; the limit is 20000
  initial begin
    #(40 * 20000);
    error_cnt++;
    stop_test();
  end
endmodule
